// ### port0_strap_config_latch.sv
// Purpose: port 0 and management configuration from latched straps
// Assumes: AXI4-Lite slave, straps sampled by strap_capture
// Notes: aresetn reloads register defaults but never re-samples pins
`timescale 1ns/100ps
module port0_strap_config_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic por_n,
  input wire logic external_reset_pin_n,
  input wire logic duplex_pol_pin,
  input wire logic [1:0] mngt_mode_pins,
  input wire logic [2:0] port0_mode_pins,
  input wire logic port0_duplex_input,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic extended_mdio_management,
  output logic i2c_management,
  output logic [1:0] port0_interface_mode,
  output logic port0_duplex_full,
  output logic port0_backpressure_enable,
  output logic port0_tx_flowctl_enable,
  output logic port0_rx_flowctl_enable,
  output logic port0_manual_flowctl_select,
  output logic heartbeat_off_bit,
  output logic refclk_direction,
  output logic clock_drive_strength
);

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  strap_cfg_pkg::strap_s straps;
  logic load_defaults;

  strap_capture u_capture (
    .aclk(aclk),
    .ce(ce),
    .por_n(por_n),
    .external_reset_pin_n(external_reset_pin_n),
    .duplex_pol_pin(duplex_pol_pin),
    .mngt_mode_pins(mngt_mode_pins),
    .port0_mode_pins(port0_mode_pins),
    .straps(straps),
    .load_defaults(load_defaults)
  );

  // ----------------------------------------
  // reset defaults from straps
  // ----------------------------------------
  logic is_mac;
  logic is_mii_phy;
  logic reload;
  logic [15:0] dflt_flowctl;
  logic [15:0] dflt_partner;
  logic [15:0] dflt_advert;
  logic [15:0] dflt_special;

  assign is_mac = (straps.port0_mode == strap_cfg_pkg::MODE_MII_MAC);
  assign is_mii_phy = (straps.port0_mode == strap_cfg_pkg::MODE_MII_PHY);
  // soft reset and strap release both reload
  assign reload = ~aresetn | load_defaults;

  // default images of the configuration registers
  always_comb begin
    dflt_flowctl = 16'h0000;
    dflt_partner = 16'h0000;
    dflt_advert = 16'h0000;
    dflt_special = 16'h0000;
    dflt_flowctl[strap_cfg_pkg::FC_BP] = straps.bp;
    dflt_flowctl[strap_cfg_pkg::FC_TX] = straps.fdfc;
    dflt_flowctl[strap_cfg_pkg::FC_RX] = straps.fdfc;
    // manual strap unused in MAC mode
    dflt_flowctl[strap_cfg_pkg::FC_MAN] = straps.manual & ~is_mac;
    dflt_partner[strap_cfg_pkg::AB_10HD] = 1'h1;
    dflt_partner[strap_cfg_pkg::AB_100HD] = 1'h1;
    dflt_partner[strap_cfg_pkg::AB_10FD] = straps.duplex_pol;
    dflt_partner[strap_cfg_pkg::AB_100FD] = straps.duplex_pol;
    dflt_partner[strap_cfg_pkg::AB_PAUSE] = straps.fdfc;
    dflt_partner[strap_cfg_pkg::AB_ASYM] = straps.fdfc;
    dflt_advert[strap_cfg_pkg::AB_PAUSE] = straps.manual & ~is_mac;
    dflt_advert[strap_cfg_pkg::AB_ASYM] = straps.manual & ~is_mac;
    // heartbeat off only in MII PHY mode
    dflt_special[strap_cfg_pkg::SC_HBOFF] = straps.heartbeat & is_mii_phy;
    dflt_special[strap_cfg_pkg::SC_REFCLK] = straps.refclk_dir;
    dflt_special[strap_cfg_pkg::SC_STRENGTH] = straps.clk_strength;
  end

  // ----------------------------------------
  // bus write path
  // ----------------------------------------
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic wr_hit;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // address map hit test
  function automatic logic addr_hit(input logic [7:0] addr);
    return (addr == strap_cfg_pkg::OFS_STATUS) || (addr == strap_cfg_pkg::OFS_FLOWCTL) ||
           (addr == strap_cfg_pkg::OFS_PARTNER) || (addr == strap_cfg_pkg::OFS_ADVERT) ||
           (addr == strap_cfg_pkg::OFS_SPECIAL);
  endfunction

  assign aw_take = awvalid & awready_ff;
  assign w_take = wvalid & wready_ff;
  assign do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_hit = addr_hit(awaddr_ff) & (awaddr_ff != strap_cfg_pkg::OFS_STATUS);

  // address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'h0;
      w_have_ff <= 1'h0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= strap_cfg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_have_ff <= 1'h1;
        awaddr_ff <= awaddr;
        awready_ff <= 1'h0;
      end
      if (w_take) begin
        w_have_ff <= 1'h1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
        wready_ff <= 1'h0;
      end
      if (do_write) begin
        aw_have_ff <= 1'h0;
        w_have_ff <= 1'h0;
        bvalid_ff <= 1'h1;
        bresp_ff <= wr_hit ? strap_cfg_pkg::RESP_OKAY : strap_cfg_pkg::RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'h0;
        awready_ff <= 1'h1;
        wready_ff <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] flowctl_ff;
  logic [15:0] partner_ff;
  logic [15:0] advert_ff;
  logic [15:0] special_ff;

  // defaults win over a software write
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (reload) begin
        flowctl_ff <= dflt_flowctl;
        partner_ff <= dflt_partner;
        advert_ff <= dflt_advert;
        special_ff <= dflt_special;
      end else if (do_write) begin
        if (awaddr_ff == strap_cfg_pkg::OFS_FLOWCTL) begin
          flowctl_ff <= wmerge(flowctl_ff, wdata_ff, wstrb_ff);
        end
        if (awaddr_ff == strap_cfg_pkg::OFS_PARTNER) begin
          partner_ff <= wmerge(partner_ff, wdata_ff, wstrb_ff);
        end
        if (awaddr_ff == strap_cfg_pkg::OFS_ADVERT) begin
          advert_ff <= wmerge(advert_ff, wdata_ff, wstrb_ff);
        end
        if (awaddr_ff == strap_cfg_pkg::OFS_SPECIAL) begin
          special_ff <= wmerge(special_ff, wdata_ff, wstrb_ff);
        end
      end
    end
  end

  // ----------------------------------------
  // bus read path
  // ----------------------------------------
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // status image of latched straps
  assign status_word = {6'h00,
                        straps.port0_mode == strap_cfg_pkg::MODE_RSVD,
                        (straps.mngt_mode != strap_cfg_pkg::MNGT_MDIO) &&
                        (straps.mngt_mode != strap_cfg_pkg::MNGT_I2C),
                        straps.duplex_pol, straps.mode_pins, straps.port0_mode, straps.mngt_mode};
  assign rd_word = (araddr == strap_cfg_pkg::OFS_STATUS) ? status_word :
                   (araddr == strap_cfg_pkg::OFS_FLOWCTL) ? flowctl_ff :
                   (araddr == strap_cfg_pkg::OFS_PARTNER) ? partner_ff :
                   (araddr == strap_cfg_pkg::OFS_ADVERT) ? advert_ff :
                   (araddr == strap_cfg_pkg::OFS_SPECIAL) ? special_ff : 16'h0000;

  // one read at a time, answer on the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= strap_cfg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'h0;
        rvalid_ff <= 1'h1;
        rdata_ff <= {16'h0000, rd_word};
        rresp_ff <= addr_hit(araddr) ? strap_cfg_pkg::RESP_OKAY : strap_cfg_pkg::RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'h0;
        arready_ff <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // direct configuration outputs
  // ----------------------------------------
  logic mdio_ff;
  logic i2c_ff;
  logic [1:0] mode_ff;
  logic duplex_full_ff;

  // duplex pin sense in MAC mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdio_ff <= 1'h0;
      i2c_ff <= 1'h0;
      mode_ff <= strap_cfg_pkg::MODE_RSVD;
      duplex_full_ff <= 1'h0;
    end else if (ce) begin
      mdio_ff <= (straps.mngt_mode == strap_cfg_pkg::MNGT_MDIO);
      i2c_ff <= (straps.mngt_mode == strap_cfg_pkg::MNGT_I2C);
      mode_ff <= straps.port0_mode;
      duplex_full_ff <= is_mac & (port0_duplex_input == straps.duplex_pol);
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign extended_mdio_management = mdio_ff;
  assign i2c_management = i2c_ff;
  assign port0_interface_mode = mode_ff;
  assign port0_duplex_full = duplex_full_ff;
  assign port0_backpressure_enable = flowctl_ff[strap_cfg_pkg::FC_BP];
  assign port0_tx_flowctl_enable = flowctl_ff[strap_cfg_pkg::FC_TX];
  assign port0_rx_flowctl_enable = flowctl_ff[strap_cfg_pkg::FC_RX];
  assign port0_manual_flowctl_select = flowctl_ff[strap_cfg_pkg::FC_MAN];
  assign heartbeat_off_bit = special_ff[strap_cfg_pkg::SC_HBOFF];
  assign refclk_direction = special_ff[strap_cfg_pkg::SC_REFCLK];
  assign clock_drive_strength = special_ff[strap_cfg_pkg::SC_STRENGTH];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic reloaded_ff;

  // marks the cycle after a default reload
  always_ff @(posedge aclk) begin
    reloaded_ff <= ce & reload;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reload_done;
    reloaded_ff && !load_defaults && por_n && external_reset_pin_n;
  endsequence

  AST_MNGT_SELECT: assert property (ce && aresetn |=>
    (mdio_ff == ($past(straps.mngt_mode) == strap_cfg_pkg::MNGT_MDIO)) &&
    (i2c_ff == ($past(straps.mngt_mode) == strap_cfg_pkg::MNGT_I2C)))
    else $error("management select does not follow strap code");
  AST_MODE_MAP: assert property (ce && aresetn |=>
    mode_ff == strap_cfg_pkg::map_mode($past(straps.mode_pins)))
    else $error("port 0 mode does not follow mode pins");
  AST_MODE_CODE: assert property (mode_ff == strap_cfg_pkg::MODE_MII_MAC |->
    $past(straps.mode_pins, 1) == 3'h0 || !$past(ce))
    else $error("MAC mode reported for nonzero mode pins");
  AST_DUPLEX_SENSE: assert property (ce && !is_mac |=> !duplex_full_ff)
    else $error("duplex reported outside MAC mode");
  AST_BP_DEFAULT: assert property (s_reload_done |->
    port0_backpressure_enable == straps.bp)
    else $error("backpressure default differs from strap");
  AST_FC_DEFAULT: assert property (s_reload_done |->
    port0_tx_flowctl_enable == straps.fdfc && port0_rx_flowctl_enable == straps.fdfc &&
    partner_ff[strap_cfg_pkg::AB_PAUSE] == straps.fdfc)
    else $error("flow control defaults differ from strap");
  AST_MANUAL_DEFAULT: assert property (s_reload_done |->
    port0_manual_flowctl_select == (straps.manual && !is_mac) &&
    advert_ff[strap_cfg_pkg::AB_ASYM] == (straps.manual && !is_mac))
    else $error("manual flow control default wrong");
  AST_HEARTBEAT: assert property (s_reload_done |->
    heartbeat_off_bit == (straps.heartbeat && is_mii_phy))
    else $error("heartbeat-off default wrong for mode");
  AST_CLOCK_DEFAULTS: assert property (s_reload_done |->
    refclk_direction == straps.mode_pins[1] && clock_drive_strength == straps.mode_pins[0])
    else $error("clock direction or strength default wrong");
  AST_WRITE_ANSWER: assert property (ce && do_write |=> bvalid_ff)
    else $error("write not answered one cycle after both parts");

endmodule

// ### strap_cfg_pkg.sv
// Purpose: shared constants, types and helpers for the port 0 strap latch
// Assumes: 32-bit register bus, one aligned word per register
// Notes: soft-strap values stand here as fixed defaults
package strap_cfg_pkg;

  // ----------------------------------------
  // bus geometry and answers
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLOWCTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PARTNER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ADVERT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SPECIAL = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  // flow control register
  localparam int FC_BP = 0;
  localparam int FC_TX = 1;
  localparam int FC_RX = 2;
  localparam int FC_MAN = 3;
  // ability / advertisement bits
  localparam int AB_10HD = 5;
  localparam int AB_10FD = 6;
  localparam int AB_100HD = 7;
  localparam int AB_100FD = 8;
  localparam int AB_PAUSE = 10;
  localparam int AB_ASYM = 11;
  // special control register
  localparam int SC_HBOFF = 0;
  localparam int SC_REFCLK = 1;
  localparam int SC_STRENGTH = 2;
  // status register
  localparam int ST_MNGT = 0;
  localparam int ST_MODE = 2;
  localparam int ST_PINS = 4;
  localparam int ST_DPOL = 7;
  localparam int ST_MNGT_RSVD = 8;
  localparam int ST_MODE_RSVD = 9;

  // ----------------------------------------
  // codes and strap defaults
  // ----------------------------------------
  localparam logic [1:0] MNGT_MDIO = 2'h1;
  localparam logic [1:0] MNGT_I2C = 2'h2;
  localparam logic BP_STRAP_DEF = 1'h1;
  localparam logic FDFC_STRAP_DEF = 1'h1;
  localparam logic MANUAL_STRAP_DEF = 1'h0;
  localparam logic HEARTBEAT_STRAP_DEF = 1'h0;

  typedef enum logic [1:0] {
    MODE_MII_MAC = 2'h0,
    MODE_MII_PHY = 2'h1,
    MODE_RMII_PHY = 2'h2,
    MODE_RSVD = 2'h3
  } port0_mode_e;

  // latched strap set
  typedef struct packed {
    logic [1:0] mngt_mode;
    logic [2:0] mode_pins;
    port0_mode_e port0_mode;
    logic duplex_pol;
    logic bp;
    logic fdfc;
    logic manual;
    logic heartbeat;
    logic refclk_dir;
    logic clk_strength;
  } strap_s;

  // three mode pins to two-bit interface mode
  function automatic port0_mode_e map_mode(input logic [2:0] pins);
    if (pins == 3'h0) begin
      return MODE_MII_MAC;
    end else if (pins <= 3'h3) begin
      return MODE_MII_PHY;
    end else if (pins <= 3'h6) begin
      return MODE_RMII_PHY;
    end else begin
      return MODE_RSVD;
    end
  endfunction

endpackage

// ### strap_capture.sv
// Purpose: sample strap pins while a qualifying reset is held, freeze after
// Assumes: por_n and external_reset_pin_n synchronous to aclk
// Notes: only these two resets open the capture window
`timescale 1ns/100ps
module strap_capture (
  input wire logic aclk,
  input wire logic ce,
  input wire logic por_n,
  input wire logic external_reset_pin_n,
  input wire logic duplex_pol_pin,
  input wire logic [1:0] mngt_mode_pins,
  input wire logic [2:0] port0_mode_pins,
  output strap_cfg_pkg::strap_s straps,
  output logic load_defaults
);

  logic qual_n;
  logic in_reset_ff;
  logic load_ff;
  strap_cfg_pkg::strap_s straps_ff;
  strap_cfg_pkg::strap_s nxt_straps;

  // qualifying reset is power-on or the external pin only
  assign qual_n = por_n & external_reset_pin_n;

  always_comb begin
    nxt_straps = straps_ff;
    nxt_straps.mngt_mode = mngt_mode_pins;
    nxt_straps.mode_pins = port0_mode_pins;
    nxt_straps.port0_mode = strap_cfg_pkg::map_mode(port0_mode_pins);
    nxt_straps.duplex_pol = duplex_pol_pin;
    nxt_straps.bp = strap_cfg_pkg::BP_STRAP_DEF;
    nxt_straps.fdfc = strap_cfg_pkg::FDFC_STRAP_DEF;
    nxt_straps.manual = strap_cfg_pkg::MANUAL_STRAP_DEF;
    nxt_straps.heartbeat = strap_cfg_pkg::HEARTBEAT_STRAP_DEF;
    nxt_straps.refclk_dir = port0_mode_pins[1];
    nxt_straps.clk_strength = port0_mode_pins[0];
  end

  always_ff @(posedge aclk) begin
    if (ce) begin
      if (!qual_n) begin
        straps_ff <= nxt_straps;
      end
      in_reset_ff <= ~qual_n;
      load_ff <= in_reset_ff & qual_n;
    end
  end

  assign straps = straps_ff;
  assign load_defaults = load_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_STRAPS_FROZEN: assert property (@(posedge aclk) disable iff (!qual_n)
    $past(qual_n) |-> $stable(straps_ff))
    else $error("strap values changed outside a qualifying reset");

  AST_LOAD_AFTER_RELEASE: assert property (@(posedge aclk) disable iff (!qual_n)
    (ce && in_reset_ff) |=> load_ff)
    else $error("no default reload after qualifying reset release");

endmodule

// ### strap_board.sv
// Purpose: board strap resistors and reset sources for port 0
// Assumes: strap levels come from the bench setting word
// Notes: power-on reset held low for the first 20 edges
`timescale 1ns/100ps
module strap_board (
  input wire logic aclk,
  input wire logic press,
  input wire logic [5:0] setting,
  output logic por_n,
  output logic external_reset_pin_n,
  output logic duplex_pol_pin,
  output logic [1:0] mngt_mode_pins,
  output logic [2:0] port0_mode_pins
);
  int cnt = 0;
  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  // only these resets
  initial begin
    por_n = 1'b0;
    external_reset_pin_n = 1'b1;
  end
  // power-on pulse then pin reset on request
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    por_n <= (cnt >= 20);
    external_reset_pin_n <= !press;
  end
  assign {duplex_pol_pin, mngt_mode_pins, port0_mode_pins} = setting;
endmodule

// ### testbench.sv
// Purpose: strap latch check through pins and register bus
// Assumes: straps reach the device through strap_board
// Notes: register bus uses fixed full byte strobes
`timescale 1ns/100ps
module testbench;
  logic aclk, aresetn, press, awvalid, wvalid, bready, arvalid, rready, port0_duplex_input;
  logic awready, wready, bvalid, arready, rvalid, por_n, external_reset_pin_n, duplex_pol_pin;
  logic extended_mdio_management, i2c_management, port0_duplex_full, port0_backpressure_enable;
  logic port0_tx_flowctl_enable, port0_rx_flowctl_enable, port0_manual_flowctl_select;
  logic heartbeat_off_bit, refclk_direction, clock_drive_strength;
  logic [1:0] port0_interface_mode, mngt_mode_pins, bresp, rresp, resp, e;
  logic [2:0] port0_mode_pins;
  logic [5:0] setting;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  int err_count = 0;
  int checks_done = 0;

  // ----------------------------------------
  // clock and instances
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  strap_board strap_board_inst (.aclk, .press, .setting, .por_n, .external_reset_pin_n, .duplex_pol_pin,
    .mngt_mode_pins, .port0_mode_pins);
  port0_strap_config_latch port0_strap_config_latch_inst (.aclk, .aresetn, .ce(1'b1), .por_n,
    .external_reset_pin_n, .duplex_pol_pin, .mngt_mode_pins, .port0_mode_pins, .port0_duplex_input,
    .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .extended_mdio_management, .i2c_management, .port0_interface_mode, .port0_duplex_full,
    .port0_backpressure_enable, .port0_tx_flowctl_enable, .port0_rx_flowctl_enable,
    .port0_manual_flowctl_select, .heartbeat_off_bit, .refclk_direction, .clock_drive_strength);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    err_count++;
    summarize();
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    err_count++;
    summarize();
  endtask
  task automatic pulse(input logic pin);
    if (pin) press <= 1'b1;
    else aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    press <= 1'b0;
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, press, awvalid, wvalid, bready, arvalid, rready, port0_duplex_input} = 8'h00;
    setting = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    // every mode pattern and management code
    for (int i = 0; i < 8; i++) begin
      setting <= {i[0] ^ i[1], i[1:0], i[2:0]};
      pulse(1'b1);
      e = (i == 0) ? 2'h0 : (i <= 3) ? 2'h1 : (i <= 6) ? 2'h2 : 2'h3;
      chk({extended_mdio_management, i2c_management}, {i[1:0] == 2'h1, i[1:0] == 2'h2});
      chk(port0_interface_mode, e);
      chk({refclk_direction, clock_drive_strength}, i[1:0]);
      chk({port0_backpressure_enable, port0_tx_flowctl_enable, port0_rx_flowctl_enable,
        port0_manual_flowctl_select, heartbeat_off_bit}, 5'h1c);
      rdr(strap_cfg_pkg::OFS_STATUS);
      chk(rd, {e == 2'h3, i[1] == i[0], i[0] ^ i[1], i[2:0], e, i[1:0]});
      rdr(strap_cfg_pkg::OFS_PARTNER);
      chk(rd, 32'hca0 | ((i[0] ^ i[1]) ? 32'h140 : 32'h0));
      rdr(strap_cfg_pkg::OFS_ADVERT);
      chk(rd, 32'h0);
      port0_duplex_input <= i[2];
      repeat (3) @(posedge aclk);
      chk(port0_duplex_full, e == 2'h0 && i[2] == (i[0] ^ i[1]));
      port0_duplex_input <= !i[2];
      repeat (3) @(posedge aclk);
      chk(port0_duplex_full, e == 2'h0 && i[2] != (i[0] ^ i[1]));
    end
    // pins change but only the bus reset follows
    setting <= 6'h00;
    pulse(1'b0);
    chk({port0_interface_mode, refclk_direction}, 3'h7);
    wr(strap_cfg_pkg::OFS_FLOWCTL, 32'h0);
    chk({port0_backpressure_enable, port0_tx_flowctl_enable}, 2'h0);
    pulse(1'b0);
    chk({port0_backpressure_enable, port0_tx_flowctl_enable}, 2'h3);
    wr(strap_cfg_pkg::OFS_STATUS, 32'h3ff);
    chk(resp, strap_cfg_pkg::RESP_SLVERR);
    rdr(8'h40);
    chk(resp, strap_cfg_pkg::RESP_SLVERR);
    summarize();
  end
endmodule
